// *** include/dfi_pkg.sv ***
`default_nettype none
package dfi_pkg;
  // register byte offsets on the apb bus
  localparam logic [7:0] OFF_FEATURE = 8'h00;
  localparam logic [7:0] OFF_DEVSEL = 8'h04;
  localparam logic [7:0] OFF_COMMAND = 8'h08;
  localparam logic [7:0] OFF_ERROR = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_DATA = 8'h14;
  localparam logic [7:0] OFF_CONFIG = 8'h18;
  localparam logic [7:0] OFF_REASSIGN = 8'h1C;
  localparam logic [7:0] OFF_DEFECT = 8'h20;
  localparam logic [7:0] OFF_PROGRESS = 8'h24;
  // opcodes
  localparam logic [7:0] CMD_FORMAT_UNIT = 8'hF7;
  localparam logic [7:0] CMD_IDENTIFY = 8'hEC;
  localparam logic [7:0] CMD_ERASE_PREP = 8'hF3;
  localparam logic [7:0] FEATURE_FORMAT = 8'h11;
  // field positions
  localparam int DEVSEL_ONE_HI = 7;
  localparam int DEVSEL_ONE_LO = 5;
  localparam int ST_BUSY = 7;
  localparam int ST_READY = 6;
  localparam int ST_SEEK_DONE = 4;
  localparam int ST_DRQ = 3;
  localparam int ST_ERR = 0;
  localparam int ER_ABORT = 2;
  // reset values
  localparam logic [7:0] STATUS_RESET = 8'h50;
  localparam logic [7:0] ERROR_RESET = 8'h00;
  localparam logic [7:0] PREV_CMD_RESET = 8'h00;
  localparam logic [2:0] CONFIG_RESET = 3'h3;
  // identification content
  localparam logic [7:0] ID_LAST_WORD = 8'hFF;
  localparam logic [15:0] ID_W0_PLAIN = 16'h045A;
  localparam logic [15:0] ID_W0_ALT = 16'h045E;
  localparam logic [15:0] ID_W2_SPIN_INCOMPLETE = 16'h37C8;
  localparam logic [15:0] ID_W2_SPIN_COMPLETE = 16'h738C;
  localparam logic [15:0] ID_W2_NOSPIN_INCOMPLETE = 16'h8C73;
  localparam logic [15:0] ID_W2_NOSPIN_COMPLETE = 16'hC837;
  localparam logic [15:0] ID_W6_SECTORS = 16'h003F;
  localparam logic [15:0] ID_W20_BUFFER_TYPE = 16'h0003;
  localparam logic [15:0] ID_W22_ECC_BYTES = 16'h0038;
  localparam logic [7:0] ID_W47_HIGH = 8'h80;
  localparam logic [15:0] ID_W48_TRUSTED = 16'h4000;
  localparam int LBA_W = 32;
  localparam int CNT_W = 16;

  typedef enum logic [1:0] {CS_IDLE, CS_FORMAT, CS_IDENT_PREP, CS_IDENT_XFER} dfi_cmd_state_type;
  typedef enum logic [1:0] {FE_IDLE, FE_MERGE, FE_INIT} dfi_fmt_phase_type;

  typedef struct packed {
    logic busy;
    logic done;
    logic [CNT_W-1:0] defects;
    logic [LBA_W-1:0] lba;
  } dfi_fmt_result_type;

  typedef struct packed {
    dfi_fmt_phase_type phase;
    logic done;
    logic [CNT_W-1:0] merged;
    logic [LBA_W-1:0] lba;
  } dfi_fmt_state_type;

  typedef struct packed {
    dfi_cmd_state_type st;
    logic [7:0] feature;
    logic [7:0] devsel;
    logic [7:0] prev_cmd;
    logic [7:0] error;
    logic [7:0] status;
    logic [2:0] cfg;
    logic [CNT_W-1:0] reassign;
    logic [CNT_W-1:0] defect;
    logic [7:0] word_ptr;
    logic fmt_start;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } dfi_top_state_type;
endpackage : dfi_pkg
`default_nettype wire

// *** hdl/dfi_ident_rom.sv ***
`timescale 1ns/1ps
`default_nettype none
module dfi_ident_rom #(
  parameter logic [159:0] SERIAL_TEXT = {20{8'h20}},
  parameter logic [63:0] FIRMWARE_TEXT = "REV00001",
  parameter logic [319:0] MODEL_TEXT = {"GENERIC DISK", {28{8'h20}}},
  parameter logic [15:0] CYLINDERS = 16'h3FFF,
  parameter logic [15:0] HEADS = 16'h0010,
  parameter logic [15:0] BUFFER_UNITS = 16'h0100,
  parameter logic [7:0] MULTI_MAX = 8'h10
) (
  input wire logic [7:0] index,
  input wire logic [2:0] cfg,
  output logic [15:0] word
);
  if (HEADS > 16'h00FF) begin : g_bad_heads
    $error("head count must fit in one byte");
  end

  always_comb begin
    word = 16'h0000;
    unique case (index) inside
      8'd0: word = cfg[2] ? dfi_pkg::ID_W0_ALT : dfi_pkg::ID_W0_PLAIN;
      8'd1: word = CYLINDERS;
      8'd2: begin
        unique case (cfg[1:0])
          2'd0: word = dfi_pkg::ID_W2_SPIN_INCOMPLETE;
          2'd1: word = dfi_pkg::ID_W2_SPIN_COMPLETE;
          2'd2: word = dfi_pkg::ID_W2_NOSPIN_INCOMPLETE;
          2'd3: word = dfi_pkg::ID_W2_NOSPIN_COMPLETE;
        endcase
      end
      8'd3: word = {8'h00, HEADS[7:0]};
      8'd6: word = dfi_pkg::ID_W6_SECTORS;
      [8'd10:8'd19]: word = SERIAL_TEXT[159 - 16 * (int'(index) - 10) -: 16];
      8'd20: word = dfi_pkg::ID_W20_BUFFER_TYPE;
      8'd21: word = BUFFER_UNITS;
      8'd22: word = dfi_pkg::ID_W22_ECC_BYTES;
      [8'd23:8'd26]: word = FIRMWARE_TEXT[63 - 16 * (int'(index) - 23) -: 16];
      [8'd27:8'd46]: word = MODEL_TEXT[319 - 16 * (int'(index) - 27) -: 16];
      8'd47: word = {dfi_pkg::ID_W47_HIGH, MULTI_MAX};
      8'd48: word = dfi_pkg::ID_W48_TRUSTED;
      // words 4,5,7,8,9 and all words past 48 read zero here
      default: word = 16'h0000;
    endcase
  end
endmodule : dfi_ident_rom
`default_nettype wire

// *** hdl/dfi_format_engine.sv ***
`timescale 1ns/1ps
`default_nettype none
module dfi_format_engine (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic [dfi_pkg::LBA_W-1:0] native_max,
  input wire logic [dfi_pkg::CNT_W-1:0] reassign_in,
  input wire logic [dfi_pkg::CNT_W-1:0] defect_in,
  output dfi_pkg::dfi_fmt_result_type result
);
  dfi_pkg::dfi_fmt_state_type state_reg;
  dfi_pkg::dfi_fmt_state_type state_next;
  logic [dfi_pkg::CNT_W:0] sum;

  assign sum = {1'b0, defect_in} + {1'b0, reassign_in};

  always_comb begin
    state_next = state_reg;
    state_next.done = 1'b0;
    unique case (state_reg.phase)
      dfi_pkg::FE_IDLE: begin
        if (start) begin
          state_next.phase = dfi_pkg::FE_MERGE;
        end
      end
      dfi_pkg::FE_MERGE: begin
        // merge first, saturate rather than wrap the count
        state_next.merged = sum[dfi_pkg::CNT_W] ? '1 : sum[dfi_pkg::CNT_W-1:0];
        state_next.lba = '0;
        state_next.phase = dfi_pkg::FE_INIT;
      end
      dfi_pkg::FE_INIT: begin
        // one sector per clock up to the native limit, no host limit seen
        if (state_reg.lba == native_max) begin
          state_next.phase = dfi_pkg::FE_IDLE;
          state_next.done = 1'b1;
        end else begin
          state_next.lba = state_reg.lba + 1'b1;
        end
      end
      default: state_next.phase = dfi_pkg::FE_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= '{phase: dfi_pkg::FE_IDLE, done: 1'b0, merged: '0, lba: '0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign result.busy = (state_reg.phase != dfi_pkg::FE_IDLE);
  assign result.done = state_reg.done;
  assign result.defects = state_reg.merged;
  assign result.lba = state_reg.lba;
endmodule : dfi_format_engine
`default_nettype wire

// *** hdl/dfi_cmd_core.sv ***
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module dfi_cmd_core #(
  parameter logic [31:0] NATIVE_MAX_LBA = 32'h0001_FFFF,
  parameter logic [159:0] SERIAL_TEXT = {20{8'h20}},
  parameter logic [63:0] FIRMWARE_TEXT = "REV00001",
  parameter logic [319:0] MODEL_TEXT = {"GENERIC DISK", {28{8'h20}}},
  parameter logic [15:0] CYLINDERS = 16'h3FFF,
  parameter logic [15:0] HEADS = 16'h0010,
  parameter logic [15:0] BUFFER_UNITS = 16'h0100,
  parameter logic [7:0] MULTI_MAX = 8'h10
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  if (NATIVE_MAX_LBA == 32'h0000_0000) begin : g_bad_max
    $error("native maximum block address must be above zero");
  end

  dfi_pkg::dfi_top_state_type state_reg;
  dfi_pkg::dfi_top_state_type state_next;
  dfi_pkg::dfi_fmt_result_type fmt_result;
  logic [15:0] ident_word;
  logic access_setup;
  logic access_done;
  logic write_done;
  logic read_done;
  logic idle;

  // status byte: ready and seek complete always shown in this device
  function automatic logic [7:0] status_value(
    input logic busy,
    input logic data_request_flag,
    input logic err
  );
    logic [7:0] v;
    v = dfi_pkg::STATUS_RESET;
    v[dfi_pkg::ST_BUSY] = busy;
    v[dfi_pkg::ST_DRQ] = data_request_flag;
    v[dfi_pkg::ST_ERR] = err;
    return v;
  endfunction : status_value

  function automatic logic addr_mapped(input logic [7:0] a);
    unique case (a)
      dfi_pkg::OFF_FEATURE,
      dfi_pkg::OFF_DEVSEL,
      dfi_pkg::OFF_COMMAND,
      dfi_pkg::OFF_ERROR,
      dfi_pkg::OFF_STATUS,
      dfi_pkg::OFF_DATA,
      dfi_pkg::OFF_CONFIG,
      dfi_pkg::OFF_REASSIGN,
      dfi_pkg::OFF_DEFECT,
      dfi_pkg::OFF_PROGRESS: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : addr_mapped

  dfi_ident_rom #(
    .SERIAL_TEXT(SERIAL_TEXT),
    .FIRMWARE_TEXT(FIRMWARE_TEXT),
    .MODEL_TEXT(MODEL_TEXT),
    .CYLINDERS(CYLINDERS),
    .HEADS(HEADS),
    .BUFFER_UNITS(BUFFER_UNITS),
    .MULTI_MAX(MULTI_MAX)
  ) u_rom (
    .index(state_reg.word_ptr),
    .cfg(state_reg.cfg),
    .word(ident_word)
  );

  dfi_format_engine u_fmt (
    .clk(clk),
    .reset_n(reset_n),
    .start(state_reg.fmt_start),
    .native_max(NATIVE_MAX_LBA),
    .reassign_in(state_reg.reassign),
    .defect_in(state_reg.defect),
    .result(fmt_result)
  );

  // one wait state: first access cycle loads prdata, second completes
  assign access_setup = psel & penable & ~state_reg.pready;
  assign access_done = psel & penable & state_reg.pready;
  assign write_done = access_done & pwrite & addr_mapped(paddr);
  assign read_done = access_done & ~pwrite;
  assign idle = (state_reg.st == dfi_pkg::CS_IDLE);

  always_comb begin
    state_next = state_reg;
    state_next.fmt_start = 1'b0;
    state_next.pready = 1'b0;
    state_next.pslverr = 1'b0;

    // read data captured in the first access cycle
    if (access_setup) begin
      state_next.pready = 1'b1;
      state_next.pslverr = ~addr_mapped(paddr);
      state_next.prdata = 32'h0000_0000;
      if (!pwrite) begin
        unique case (paddr)
          dfi_pkg::OFF_DEVSEL: state_next.prdata = {24'h00_0000, state_reg.devsel};
          dfi_pkg::OFF_ERROR: state_next.prdata = {24'h00_0000, state_reg.error};
          dfi_pkg::OFF_STATUS: state_next.prdata = {24'h00_0000, state_reg.status};
          dfi_pkg::OFF_DATA: begin
            if (state_reg.st == dfi_pkg::CS_IDENT_XFER) begin
              state_next.prdata = {16'h0000, ident_word};
            end
          end
          dfi_pkg::OFF_CONFIG: state_next.prdata = {29'h0000_0000, state_reg.cfg};
          dfi_pkg::OFF_REASSIGN: state_next.prdata = {16'h0000, state_reg.reassign};
          dfi_pkg::OFF_DEFECT: state_next.prdata = {16'h0000, state_reg.defect};
          dfi_pkg::OFF_PROGRESS: state_next.prdata = fmt_result.lba;
          default: state_next.prdata = 32'h0000_0000;
        endcase
      end
    end

    // writes; block registers are locked while a command runs
    if (write_done && idle) begin
      unique case (paddr)
        dfi_pkg::OFF_FEATURE: state_next.feature = pwdata[7:0];
        dfi_pkg::OFF_DEVSEL: state_next.devsel = pwdata[7:0];
        dfi_pkg::OFF_CONFIG: state_next.cfg = pwdata[2:0];
        dfi_pkg::OFF_REASSIGN: state_next.reassign = pwdata[dfi_pkg::CNT_W-1:0];
        dfi_pkg::OFF_COMMAND: begin
          // every accepted opcode becomes the one seen before the next
          state_next.prev_cmd = pwdata[7:0];
          unique case (pwdata[7:0])
            dfi_pkg::CMD_FORMAT_UNIT: begin
              if (state_reg.prev_cmd == dfi_pkg::CMD_ERASE_PREP &&
                  state_reg.devsel[dfi_pkg::DEVSEL_ONE_HI] &&
                  state_reg.devsel[dfi_pkg::DEVSEL_ONE_LO]) begin
                state_next.st = dfi_pkg::CS_FORMAT;
                state_next.fmt_start = 1'b1;
                state_next.error = dfi_pkg::ERROR_RESET;
                state_next.status = status_value(1'b1, 1'b0, 1'b0);
              end else begin
                state_next.error = dfi_pkg::ERROR_RESET;
                state_next.error[dfi_pkg::ER_ABORT] = 1'b1;
                state_next.status = status_value(1'b0, 1'b0, 1'b1);
              end
            end
            dfi_pkg::CMD_IDENTIFY: begin
              state_next.st = dfi_pkg::CS_IDENT_PREP;
              state_next.error = dfi_pkg::ERROR_RESET;
              state_next.status = status_value(1'b1, 1'b0, 1'b0);
            end
            dfi_pkg::CMD_ERASE_PREP: begin
              // arms the next format unit; nothing else to do
              state_next.error = dfi_pkg::ERROR_RESET;
              state_next.status = status_value(1'b0, 1'b0, 1'b0);
            end
            default: begin
              state_next.error = dfi_pkg::ERROR_RESET;
              state_next.error[dfi_pkg::ER_ABORT] = 1'b1;
              state_next.status = status_value(1'b0, 1'b0, 1'b1);
            end
          endcase
        end
        default: begin
        end
      endcase
    end

    unique case (state_reg.st)
      dfi_pkg::CS_IDLE: begin
      end
      dfi_pkg::CS_FORMAT: begin
        // data request never raised while formatting
        state_next.status[dfi_pkg::ST_DRQ] = 1'b0;
        if (fmt_result.done) begin
          // records swapped in the same edge that drops busy
          state_next.defect = fmt_result.defects;
          state_next.reassign = '0;
          state_next.status = status_value(1'b0, 1'b0, 1'b0);
          state_next.st = dfi_pkg::CS_IDLE;
        end
      end
      dfi_pkg::CS_IDENT_PREP: begin
        state_next.word_ptr = 8'h00;
        state_next.status = status_value(1'b0, 1'b1, 1'b0);
        state_next.st = dfi_pkg::CS_IDENT_XFER;
      end
      dfi_pkg::CS_IDENT_XFER: begin
        // each completed data read hands over one word
        if (read_done && paddr == dfi_pkg::OFF_DATA) begin
          state_next.word_ptr = state_reg.word_ptr + 8'h01;
          if (state_reg.word_ptr == dfi_pkg::ID_LAST_WORD) begin
            state_next.status = status_value(1'b0, 1'b0, 1'b0);
            state_next.st = dfi_pkg::CS_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= '{
        st: dfi_pkg::CS_IDLE,
        feature: 8'h00,
        devsel: 8'h00,
        prev_cmd: dfi_pkg::PREV_CMD_RESET,
        error: dfi_pkg::ERROR_RESET,
        status: dfi_pkg::STATUS_RESET,
        cfg: dfi_pkg::CONFIG_RESET,
        reassign: '0,
        defect: '0,
        word_ptr: 8'h00,
        fmt_start: 1'b0,
        pready: 1'b0,
        pslverr: 1'b0,
        prdata: 32'h0000_0000
      };
    end else begin
      state_reg <= state_next;
    end
  end

  assign prdata = state_reg.prdata;
  assign pready = state_reg.pready;
  assign pslverr = state_reg.pslverr;
endmodule : dfi_cmd_core
`default_nettype wire

// *** tb/dfi_cmd_core_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module dfi_cmd_core_sva (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  logic [8:0] word_idx;
  logic fmt_run;
  logic rd_done;
  logic cmd_done;
  assign rd_done = psel && penable && pready && !pwrite;
  assign cmd_done = psel && penable && pready && pwrite && paddr == dfi_pkg::OFF_COMMAND;
  // index of the next identify word; all ones means no sector is open
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      word_idx <= 9'h1FF;
      fmt_run <= 1'b0;
    end else if (cmd_done) begin
      word_idx <= (pwdata[7:0] == dfi_pkg::CMD_IDENTIFY) ? 9'h000 : 9'h1FF;
      fmt_run <= pwdata[7:0] == dfi_pkg::CMD_FORMAT_UNIT;
    end else if (rd_done && paddr == dfi_pkg::OFF_DATA && word_idx != 9'h1FF) begin
      word_idx <= word_idx + 9'h001;
    end else if (rd_done && paddr == dfi_pkg::OFF_STATUS && !prdata[7]) begin
      fmt_run <= 1'b0;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_ready_one_wait: assert property (psel && $rose(penable) |-> !pready ##1 pready)
    else $error("pready not after one wait state");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_unmapped_err: assert property (pready && paddr > dfi_pkg::OFF_PROGRESS |-> pslverr)
    else $error("unmapped access without pslverr");
  a_mapped_no_err: assert property (pready && paddr <= dfi_pkg::OFF_PROGRESS
    && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("mapped access with pslverr");
  a_upper_zero: assert property (rd_done && paddr != dfi_pkg::OFF_PROGRESS
    |-> prdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  a_err_not_busy: assert property (rd_done && paddr == dfi_pkg::OFF_STATUS
    && prdata[0] |-> !prdata[7])
    else $error("error flag while busy");
  a_fmt_no_drq: assert property (rd_done && fmt_run && paddr == dfi_pkg::OFF_STATUS
    |-> !prdata[3])
    else $error("data request during format");
  a_id_word_zero: assert property (rd_done && paddr == dfi_pkg::OFF_DATA
    && word_idx == 9'h000 |-> prdata[15:0] inside {16'h045A, 16'h045E})
    else $error("identify word 0 wrong");
  a_id_word_two: assert property (rd_done && paddr == dfi_pkg::OFF_DATA
    && word_idx == 9'h002 |-> prdata[15:0] inside {16'h37C8, 16'h738C, 16'h8C73, 16'hC837})
    else $error("identify word 2 wrong");
  a_id_word_six: assert property (rd_done && paddr == dfi_pkg::OFF_DATA
    && word_idx == 9'h006 |-> prdata[15:0] == 16'h003F)
    else $error("identify word 6 wrong");
  a_id_word_trust: assert property (rd_done && paddr == dfi_pkg::OFF_DATA
    && word_idx == 9'h030 |-> prdata[15:0] == 16'h4000)
    else $error("identify word 48 wrong");
endmodule : dfi_cmd_core_sva
bind dfi_cmd_core dfi_cmd_core_sva u_sva (.clk(clk), .reset_n(reset_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr));
`default_nettype wire

// *** tb/dfi_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module dfi_host_model (
  input wire logic clk,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output var logic psel,
  output var logic penable,
  output var logic pwrite,
  output var logic [7:0] paddr,
  output var logic [31:0] pwdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'hFF;
    pwdata = 32'h0000_0000;
  end
  // entered just after a rising edge; returns just after one
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // wait states are the slave's business; only the bench timeout ends this wait
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
    // idle cycle keeps a following call from reassigning psel in this time step
    @(posedge clk);
  endtask : xfer
endmodule : dfi_host_model
`default_nettype wire

// *** tb/dfi_cmd_core_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module dfi_cmd_core_tb;
  localparam logic [31:0] MAX_LBA = 32'h0000_0010;
  localparam logic [63:0] FW = "REV00001";
  localparam logic [319:0] MODEL = {"GENERIC DISK", {28{8'h20}}};
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  int failures = 0;
  int num_checks = 0;
  int cycles = 0;
  dfi_cmd_core #(.NATIVE_MAX_LBA(MAX_LBA)) uut (.clk(clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  dfi_host_model host (.clk(clk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  initial forever #50 clk = ~clk;
  task automatic complete_run;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      $display("unexpected at %0t: run did not finish", $time);
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic e;
    host.xfer(1'b1, a, d, rdata, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    host.xfer(1'b0, a, 32'h0000_0000, q, e);
  endtask : rd
  function automatic logic [15:0] exp_word(input int i, input logic [2:0] cfg);
    logic [63:0] codes;
    codes = {16'h37C8, 16'h738C, 16'h8C73, 16'hC837};
    if (i == 0) return cfg[2] ? 16'h045E : 16'h045A;
    if (i == 1) return 16'h3FFF;
    if (i == 2) return codes[(3 - cfg[1:0]) * 16 +: 16];
    if (i == 3) return 16'h0010;
    if (i == 6) return 16'h003F;
    if (i >= 10 && i <= 19) return 16'h2020;
    if (i == 20) return 16'h0003;
    if (i == 21) return 16'h0100;
    if (i == 22) return 16'h0038;
    if (i >= 23 && i <= 26) return FW[(26 - i) * 16 +: 16];
    if (i >= 27 && i <= 46) return MODEL[(46 - i) * 16 +: 16];
    if (i == 47) return 16'h8010;
    if (i == 48) return 16'h4000;
    return 16'h0000;
  endfunction : exp_word
  // polls status; a 200-poll bound stands in for the capacity-derived one
  task automatic wait_idle(output logic [31:0] q);
    int n;
    n = 0;
    rd(dfi_pkg::OFF_STATUS, q);
    while (q[7] !== 1'b0 && n < 200) begin
      chk({31'h0, q[3]}, 32'h0000_0000);
      rd(dfi_pkg::OFF_STATUS, q);
      n++;
    end
  endtask : wait_idle
  task automatic ident(input logic [2:0] cfg);
    logic [31:0] q;
    wr(dfi_pkg::OFF_CONFIG, {29'h0, cfg});
    wr(dfi_pkg::OFF_COMMAND, {24'h0, dfi_pkg::CMD_IDENTIFY});
    wait_idle(q);
    chk(q, 32'h0000_0058);
    for (int i = 0; i < 256; i++) begin
      rd(dfi_pkg::OFF_DATA, q);
      chk(q, {16'h0, exp_word(i, cfg)});
    end
    rd(dfi_pkg::OFF_STATUS, q);
    chk(q, 32'h0000_0050);
  endtask : ident
  task automatic expect_abort;
    logic [31:0] q;
    rd(dfi_pkg::OFF_ERROR, q);
    chk(q, 32'h0000_0004);
    rd(dfi_pkg::OFF_STATUS, q);
    chk(q, 32'h0000_0051);
  endtask : expect_abort
  // pre is an opcode slipped in between erase prepare and format; zero for none
  task automatic fmt(input logic [7:0] sel, input logic [7:0] pre, input logic ok,
    input logic [31:0] defects);
    logic [31:0] q;
    wr(dfi_pkg::OFF_DEVSEL, {24'h0, sel});
    wr(dfi_pkg::OFF_FEATURE, {24'h0, dfi_pkg::FEATURE_FORMAT});
    wr(dfi_pkg::OFF_COMMAND, {24'h0, dfi_pkg::CMD_ERASE_PREP});
    if (pre != 8'h00) wr(dfi_pkg::OFF_COMMAND, {24'h0, pre});
    // a data-in command locks the block until its sector is drained
    if (pre == dfi_pkg::CMD_IDENTIFY) repeat (256) rd(dfi_pkg::OFF_DATA, q);
    wr(dfi_pkg::OFF_COMMAND, {24'h0, dfi_pkg::CMD_FORMAT_UNIT});
    if (ok) begin
      rd(dfi_pkg::OFF_STATUS, q);
      chk(q, 32'h0000_00D0);
      wait_idle(q);
      chk(q, 32'h0000_0050);
      rd(dfi_pkg::OFF_DEFECT, q);
      chk(q, defects);
      rd(dfi_pkg::OFF_REASSIGN, q);
      chk(q, 32'h0000_0000);
      rd(dfi_pkg::OFF_PROGRESS, q);
      chk(q, MAX_LBA);
    end else begin
      expect_abort();
    end
  endtask : fmt
  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rd(dfi_pkg::OFF_STATUS, rdata);
    chk(rdata, 32'h0000_0050);
    rd(dfi_pkg::OFF_ERROR, rdata);
    chk(rdata, 32'h0000_0000);
    rd(dfi_pkg::OFF_CONFIG, rdata);
    chk(rdata, 32'h0000_0003);
    rd(dfi_pkg::OFF_FEATURE, rdata);
    chk(rdata, 32'h0000_0000);
    host.xfer(1'b0, 8'h28, 32'h0000_0000, rdata, err);
    chk({31'h0, err}, 32'h0000_0001);
    wr(dfi_pkg::OFF_REASSIGN, 32'h0000_0005);
    rd(dfi_pkg::OFF_REASSIGN, rdata);
    chk(rdata, 32'h0000_0005);
    // every word 2 code, and both word 0 forms
    for (int k = 0; k < 4; k++) ident({k[0], k[1:0]});
    fmt(8'hE0, dfi_pkg::CMD_IDENTIFY, 1'b0, 32'h0000_0000);
    fmt(8'h80, 8'h00, 1'b0, 32'h0000_0000);
    fmt(8'hA0, 8'h00, 1'b1, 32'h0000_0005);
    wr(dfi_pkg::OFF_COMMAND, {24'h0, dfi_pkg::CMD_FORMAT_UNIT});
    expect_abort();
    wr(dfi_pkg::OFF_COMMAND, 32'h0000_0020);
    expect_abort();
    wr(dfi_pkg::OFF_REASSIGN, 32'h0000_0003);
    fmt(8'hE0, 8'h00, 1'b1, 32'h0000_0008);
    complete_run();
  end
endmodule : dfi_cmd_core_tb
`default_nettype wire
